// ---- rtl/traffic_test_generator.sv ----
// test traffic generator and checker for a many-command storage host core
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module traffic_test_generator
	import traffic_test_pkg::*;
#(
	parameter int AXI_ADDR_BITS = 8
) (
	// clock, reset, enable
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     clk_en,
	// register bus
	input  wire logic [AXI_ADDR_BITS-1:0] s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [AXI_ADDR_BITS-1:0] s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// command stream
	output logic                          cmd_request_valid,
	output logic [ADDR_BITS-1:0]          target_address,
	input  wire logic                     cmd_accept_ready,
	input  wire logic [COUNT_BITS-1:0]    outstanding_command_count,
	// write stream
	output logic                          write_beat_valid,
	output logic [BEAT_BITS-1:0]          write_beat_payload,
	input  wire logic                     write_accept_ready,
	// read stream
	input  wire logic                     read_beat_valid,
	input  wire logic [BEAT_BITS-1:0]     read_beat_payload
);

	// ----------------------------------------------------------------
	// pattern helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[30] ^ s[20] ^ s[0]};
	endfunction

	function automatic logic [31:0] lfsr_adv4(input logic [31:0] s);
		logic [31:0] t;
		t = s;
		for (int i = 0; i < 4; i++) begin
			t = lfsr_step(t);
		end
		return t;
	endfunction

	function automatic logic [31:0] lfsr_seed(input logic [ADDR_BITS-1:0] a);
		return a[31:0] | LFSR_SEED_SET;
	endfunction

	// one 128-bit beat: four dwords of pattern, header over dw0/dw1 of beat 0 except in the zero and one patterns
	function automatic logic [BEAT_BITS-1:0] make_beat(input logic [7:0] idx, input logic [ADDR_BITS-1:0] hdr,
			input logic [31:0] seed, input logic [2:0] sel);
		logic [BEAT_BITS-1:0] b;
		logic [31:0]          s;
		logic [31:0]          n;
		b = '0;
		s = seed;
		for (int i = 0; i < 4; i++) begin
			n = {22'h000000, idx, 2'(i)};                    // [R12]
			case (sel)
				PAT_INC:  b[32*i +: 32] = n;                 // [R12]
				PAT_DEC:  b[32*i +: 32] = ~n;                // [R13]
				PAT_LFSR: b[32*i +: 32] = s;                 // [R14]
				PAT_ZERO: b[32*i +: 32] = 32'h0000_0000;
				PAT_ONE:  b[32*i +: 32] = 32'hffff_ffff;
				default:  b[32*i +: 32] = n;
			endcase
			s = lfsr_step(s);                                // [R14]
		end
		if (idx == 8'h00 && sel != PAT_ZERO && sel != PAT_ONE) begin // [R15]
			b[63:0] = {16'h0000, hdr};                       // [R11]
		end
		return b;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	control_t             ctrl_q;
	wr_state_t            state_q;
	logic [7:0]           beat_counter_q;
	logic [ADDR_BITS-1:0] header_q;
	logic [31:0]          lfsr_q;
	logic [BEAT_BITS-1:0] payload_q;
	logic [BEAT_BITS-1:0] expected_payload_q;
	logic [BEAT_BITS-1:0] read_data_q;
	logic                 delayed_read_valid_q;
	logic                 read_valid_prev_q;
	logic                 feed_starvation_flag_q;
	logic                 verify_fail_flag_q;
	logic [31:0]          addr_lo_q;
	logic [31:0]          pop_total_q;

	logic [AXI_ADDR_BITS-1:0] aw_addr_q;
	logic                     aw_held_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	logic                     w_held_q;
	logic                     bvalid_q;
	logic [1:0]               bresp_q;
	logic                     rvalid_q;
	logic [1:0]               rresp_q;
	logic [31:0]              rdata_q;

	// queue signals: index 0 issue, 1 header
	logic                 push;
	logic [1:0]           pop;
	logic [1:0]           q_empty;
	logic [1:0]           q_full;
	logic [10:0]          q_count [2];
	logic [ADDR_BITS-1:0] q_head  [2];

	logic                 do_write;
	logic [7:0]           wr_off;
	logic [31:0]          wr_merged;
	logic                 issue_queue_pop;
	logic                 header_queue_pop;
	logic                 read_block_start;
	logic [10:0]          queue_free_count;
	logic [31:0]          completed_command_count;

	// ----------------------------------------------------------------
	// address queues
	// ----------------------------------------------------------------
	for (genvar gi = 0; gi < 2; gi++) begin : g_queue
		logic [ADDR_BITS-1:0] mem_q [QUEUE_DEPTH];
		logic [9:0]           wr_ptr_q;
		logic [9:0]           rd_ptr_q;
		logic [10:0]          count_q;
		logic                 do_push;
		logic                 do_pop;

		assign do_push = push && !q_full[gi];
		assign do_pop  = pop[gi] && !q_empty[gi];

		always_ff @(posedge aclk) begin
			if (clk_en && do_push) begin
				mem_q[wr_ptr_q] <= {aw_held_q ? w_data_q[15:0] : 16'h0000, addr_lo_q};
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin                                  // [R22]
				wr_ptr_q <= '0;
				rd_ptr_q <= '0;
				count_q  <= '0;
			end else if (clk_en) begin
				if (do_push) wr_ptr_q <= wr_ptr_q + 10'h001;
				if (do_pop) rd_ptr_q <= rd_ptr_q + 10'h001;
				count_q <= count_q + {10'h000, do_push} - {10'h000, do_pop};
			end
		end

		// look-ahead head: the entry shows before it is popped
		assign q_head[gi]  = mem_q[rd_ptr_q];                    // [R01]
		assign q_count[gi] = count_q;
		assign q_empty[gi] = (count_q == 11'h000);
		assign q_full[gi]  = (count_q == 11'(QUEUE_DEPTH));
	end

	// ----------------------------------------------------------------
	// command issue and counters
	// ----------------------------------------------------------------
	// gated by the enable so that a frozen block never offers a command that it does not pop
	assign issue_queue_pop   = clk_en && ctrl_q.run && !q_empty[0] && cmd_accept_ready; // [R06]
	assign cmd_request_valid = issue_queue_pop;                  // [R06]
	assign target_address    = q_head[0];
	assign pop[0]            = issue_queue_pop;

	// at most 32 commands sit in the core, so this margin bounds queue skew
	assign queue_free_count = (q_count[0] > 11'(QUEUE_DEPTH - FREE_MARGIN)) ? 11'h000
		: 11'(QUEUE_DEPTH - FREE_MARGIN) - q_count[0];          // [R02] [R03]

	assign completed_command_count = pop_total_q - {26'h0000000, outstanding_command_count}; // [R04]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pop_total_q <= '0;                                   // [R22]
		end else if (clk_en && issue_queue_pop) begin
			pop_total_q <= pop_total_q + 32'h0000_0001;          // [R04]
		end
	end

	// ----------------------------------------------------------------
	// write stream and beat tracking
	// ----------------------------------------------------------------
	assign header_queue_pop = (ctrl_q.run && !ctrl_q.direction_select && state_q == st_wait
		&& !q_empty[1] && write_accept_ready)                   // [R07] [R21]
		|| (ctrl_q.direction_select && read_block_start);       // [R17]
	assign pop[1]             = header_queue_pop;
	assign write_beat_valid   = (state_q == st_emit);            // [R08]
	assign write_beat_payload = payload_q;

	// back-to-back blocks have no valid edge, so a wrapped counter also starts one
	assign read_block_start = read_beat_valid && (!read_valid_prev_q || beat_counter_q == 8'h00); // [R17] [R19]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q        <= st_wait;                           // [R22]
			beat_counter_q <= '0;
			header_q       <= '0;
			lfsr_q         <= LFSR_SEED_SET;
			payload_q      <= '0;
		end else if (clk_en) begin
			case (state_q)
				st_wait: begin
					if (header_queue_pop && !ctrl_q.direction_select) begin // [R07]
						header_q       <= q_head[1];             // [R11]
						beat_counter_q <= 8'h00;
						payload_q      <= make_beat(8'h00, q_head[1], lfsr_seed(q_head[1]), ctrl_q.pattern_select);
						lfsr_q         <= lfsr_adv4(lfsr_seed(q_head[1])); // [R14]
						state_q        <= st_emit;
					end else if (ctrl_q.direction_select && read_beat_valid) begin
						beat_counter_q <= beat_counter_q + 8'h01;     // [R09]
						if (read_block_start) begin
							header_q <= q_head[1];
							lfsr_q   <= lfsr_adv4(lfsr_seed(q_head[1]));
						end else begin
							lfsr_q <= lfsr_adv4(lfsr_q);
						end
					end
				end
				st_emit: begin
					beat_counter_q <= beat_counter_q + 8'h01;    // [R08]
					payload_q      <= make_beat(beat_counter_q + 8'h01, header_q, lfsr_q, ctrl_q.pattern_select);
					lfsr_q         <= lfsr_adv4(lfsr_q);
					if (beat_counter_q == 8'hff) begin
						state_q <= st_settle;                    // [R08]
					end
				end
				st_settle: begin
					state_q <= st_wait;                          // [R10] [R20]
				end
				default: begin
					state_q <= st_wait;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read check
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			delayed_read_valid_q <= 1'b0;
			read_valid_prev_q    <= 1'b0;
			read_data_q          <= '0;
			expected_payload_q   <= '0;
		end else if (clk_en) begin
			read_valid_prev_q    <= read_beat_valid;
			delayed_read_valid_q <= read_beat_valid;             // [R18]
			read_data_q          <= read_beat_payload;           // [R18]
			if (read_block_start) begin
				expected_payload_q <= make_beat(8'h00, q_head[1], lfsr_seed(q_head[1]), ctrl_q.pattern_select);
			end else if (read_beat_valid) begin
				expected_payload_q <= make_beat(beat_counter_q, header_q, lfsr_q, ctrl_q.pattern_select);
			end
		end
	end

	// ----------------------------------------------------------------
	// sticky flags, event beats a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feed_starvation_flag_q <= 1'b0;                      // [R22]
			verify_fail_flag_q     <= 1'b0;
		end else if (clk_en) begin
			if (ctrl_q.run && q_empty[0]) begin
				feed_starvation_flag_q <= 1'b1;                  // [R05]
			end else if (do_write && wr_off == OFF_STATUS && wr_merged[STAT_STARVE_BIT]) begin
				feed_starvation_flag_q <= 1'b0;
			end
			if (delayed_read_valid_q && ctrl_q.verify_enable && read_data_q != expected_payload_q) begin
				verify_fail_flag_q <= 1'b1;                      // [R16]
			end else if (do_write && wr_off == OFF_STATUS && wr_merged[STAT_FAIL_BIT]) begin
				verify_fail_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready  = !w_held_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	assign do_write  = aw_held_q && w_held_q && !bvalid_q;
	assign wr_off    = {aw_addr_q[7:2], 2'b00};
	assign push      = do_write && wr_off == OFF_ADDR_HI;       // [R01]
	always_comb begin
		wr_merged = '0;
		for (int i = 0; i < 4; i++) begin
			wr_merged[8*i +: 8] = w_strb_q[i] ? w_data_q[8*i +: 8] : 8'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			ctrl_q    <= CONTROL_RESET;
			addr_lo_q <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && !aw_held_q) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_q) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= RESP_OKAY;
				case (wr_off)
					OFF_CONTROL: if (w_strb_q[0]) ctrl_q <= control_t'(
						{w_data_q[CTRL_PAT_LSB +: 3], w_data_q[CTRL_VERIFY_BIT],
						w_data_q[CTRL_DIR_BIT], w_data_q[CTRL_RUN_BIT]});
					OFF_ADDR_LO: addr_lo_q <= wr_merged;
					OFF_STATUS, OFF_ADDR_HI, OFF_FREE, OFF_DONE: bresp_q <= RESP_OKAY;
					default: bresp_q <= RESP_SLVERR;
				endcase
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rresp_q  <= RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
					OFF_CONTROL: rdata_q <= {25'h0000000, ctrl_q.pattern_select, 1'b0,
						ctrl_q.verify_enable, ctrl_q.direction_select, ctrl_q.run};
					OFF_STATUS:  rdata_q <= {28'h0000000, q_empty[1], q_empty[0],
						verify_fail_flag_q, feed_starvation_flag_q};
					OFF_ADDR_LO: rdata_q <= addr_lo_q;
					OFF_ADDR_HI: rdata_q <= 32'h0000_0000;
					OFF_FREE:    rdata_q <= {21'h000000, queue_free_count};
					OFF_DONE:    rdata_q <= completed_command_count;
					default: begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= RESP_SLVERR;
					end
				endcase
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule // traffic_test_generator

// ---- rtl/traffic_test_pkg.sv ----
// constants, field layouts and carrier types of the traffic test generator
// Functional notes
// [R01] - two 1024-deep look-ahead queues of 48-bit addresses
// [R02] - free count is depth minus fill minus 32
// [R03] - core takes at most 32 outstanding commands
// [R04] - completed count is pops minus outstanding count
// [R05] - starvation flag when issue queue empty during run
// [R06] - issue pop is the command request valid
// [R07] - wait: header present and ready, pop once
// [R08] - emit: 256 beats of valid, 8-bit counter
// [R09] - reads: beat counter counts read valid beats
// [R10] - one settle cycle after last write beat
// [R11] - block starts with 64-bit header from address
// [R12] - selectable pattern; incrementing from up-counter
// [R13] - decrementing pattern is inverted incrementing value
// [R14] - LFSR x^31+x^21+x+1, four values per cycle
// [R15] - zero and one patterns carry no header
// [R16] - compare read beats, set fail on mismatch
// [R17] - read valid rising edge pops header queue
// [R18] - read valid and data delayed one stage
// [R19] - core returns 256 contiguous read beats
// [R20] - core updates write ready between blocks
// [R21] - direction low means write
// [R22] - reset idles machine, clears counters, flags, queues
package traffic_test_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int ADDR_BITS   = 48;
	localparam int QUEUE_DEPTH = 1024;
	localparam int FREE_MARGIN = 32;
	localparam int BEAT_BITS   = 128;
	localparam int COUNT_BITS  = 6;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_ADDR_LO = 8'h08;
	localparam logic [7:0] OFF_ADDR_HI = 8'h0c;
	localparam logic [7:0] OFF_FREE    = 8'h10;
	localparam logic [7:0] OFF_DONE    = 8'h14;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_DIR_BIT    = 1;
	localparam int CTRL_VERIFY_BIT = 2;
	localparam int CTRL_PAT_LSB    = 4;
	localparam int STAT_STARVE_BIT = 0;
	localparam int STAT_FAIL_BIT   = 1;
	localparam int STAT_IEMPTY_BIT = 2;
	localparam int STAT_HEMPTY_BIT = 3;
	localparam logic [31:0] LFSR_SEED_SET = 32'h0000_0001;

	// ----------------------------------------------------------------
	// pattern codes
	// ----------------------------------------------------------------
	localparam logic [2:0] PAT_INC  = 3'h0;
	localparam logic [2:0] PAT_DEC  = 3'h1;
	localparam logic [2:0] PAT_LFSR = 3'h2;
	localparam logic [2:0] PAT_ZERO = 3'h3;
	localparam logic [2:0] PAT_ONE  = 3'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {st_wait, st_emit, st_settle} wr_state_t;

	typedef struct packed {
		logic [2:0] pattern_select;
		logic       verify_enable;
		logic       direction_select;
		logic       run;
	} control_t;

	localparam control_t CONTROL_RESET = '0;

endpackage

// ---- test/traffic_test_props.sv ----
// concurrent checks on the traffic test generator ports
`timescale 1ns/1ps
module traffic_test_props (
	// clock, reset
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	// register bus
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// streams
	input wire logic        cmd_request_valid,
	input wire logic        cmd_accept_ready,
	input wire logic        write_beat_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------------
	// beat run length
	// ----------------------------------------------------------------
	logic [8:0] run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) run_q <= 9'h0;
		else if (clk_en) run_q <= write_beat_valid ? run_q + 9'h1 : 9'h0;
	end
	cmd_ready_a: assert property (cmd_request_valid |-> cmd_accept_ready)
		else $error("command issued without ready");
	emit_len_a: assert property ($fell(write_beat_valid) |-> run_q == 9'h100)
		else $error("write block not 256 beats");
	emit_max_a: assert property (run_q <= 9'h100)
		else $error("write valid longer than 256 beats");
	settle_gap_a: assert property ($fell(write_beat_valid) |-> !write_beat_valid ##1 !write_beat_valid)
		else $error("no settle cycle after block");
	reset_idle_a: assert property ($rose(aresetn) |-> !cmd_request_valid && !write_beat_valid && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	cover property ($fell(write_beat_valid));
	cover property (cmd_request_valid);
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule // traffic_test_props

bind traffic_test_generator traffic_test_props traffic_test_props_inst (.aclk, .aresetn, .clk_en, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cmd_request_valid,
	.cmd_accept_ready, .write_beat_valid);

// ---- test/core_model.sv ----
// far-side storage core model: command, write and read streams
`timescale 1ns/1ps
module core_model
	import traffic_test_pkg::*;
(
	// clock, reset, bench controls
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 stall,
	input  wire logic                 rd_mode,
	input  wire logic                 bad,
	// streams
	input  wire logic                 cmd_request_valid,
	input  wire logic [ADDR_BITS-1:0] target_address,
	output logic                      cmd_accept_ready,
	output logic [COUNT_BITS-1:0]     outstanding_command_count,
	input  wire logic                 write_beat_valid,
	input  wire logic [BEAT_BITS-1:0] write_beat_payload,
	output logic                      write_accept_ready,
	output logic                      read_beat_valid,
	output logic [BEAT_BITS-1:0]      read_beat_payload,
	// captures
	output logic [BEAT_BITS-1:0]      beat0_q,
	output logic [BEAT_BITS-1:0]      beat1_q,
	output logic [ADDR_BITS-1:0]      addr_q,
	output int                        blocks_q
);
	logic [7:0] wcnt_q, rcnt_q;
	logic       rpend_q, wdone, rdone;
	function automatic logic [BEAT_BITS-1:0] beat(input logic [ADDR_BITS-1:0] ad, input logic [7:0] k);
		logic [31:0] b;
		b = {22'h0, k, 2'h0};
		beat = {b + 32'h3, b + 32'h2, b + 32'h1, b};
		if (k == 8'h0) beat[63:0] = {16'h0, ad};
	endfunction
	assign wdone = write_beat_valid && wcnt_q == 8'hff;
	assign rdone = read_beat_valid && rcnt_q == 8'hff;
	assign cmd_accept_ready = outstanding_command_count < 6'h20;
	assign write_accept_ready = !stall;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outstanding_command_count <= '0;
			{wcnt_q, rcnt_q, rpend_q, read_beat_valid} <= '0;
			read_beat_payload <= '0;
			blocks_q <= 0;
		end else begin
			outstanding_command_count <= outstanding_command_count + 6'(cmd_request_valid) - 6'(wdone || rdone);
			if (cmd_request_valid) begin
				addr_q <= target_address;
				rpend_q <= rd_mode;
			end
			if (wdone || rdone) blocks_q <= blocks_q + 1;
			if (write_beat_valid) wcnt_q <= wcnt_q + 8'h1;
			if (write_beat_valid && wcnt_q == 8'h0) beat0_q <= write_beat_payload;
			if (write_beat_valid && wcnt_q == 8'h1) beat1_q <= write_beat_payload;
			if (read_beat_valid) begin
				rcnt_q <= rcnt_q + 8'h1;
				read_beat_valid <= !rdone;
				read_beat_payload <= rdone ? ~read_beat_payload : beat(addr_q, rcnt_q + 8'h1) ^ 128'(bad && rcnt_q == 8'h6);
			end else if (rpend_q) begin
				read_beat_valid <= 1'h1;
				read_beat_payload <= beat(addr_q, 8'h0);
				rpend_q <= 1'h0;
			end
		end
	end
endmodule // core_model

// ---- test/traffic_test_generator_tb.sv ----
// self-checking bench for the traffic test generator
`timescale 1ns/1ps
module traffic_test_generator_tb
	import traffic_test_pkg::*;
;
	logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, stall = 1'h1, rd_mode = 1'h0, bad = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, e;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic cmd_request_valid, cmd_accept_ready, write_beat_valid, write_accept_ready, read_beat_valid;
	logic [ADDR_BITS-1:0] target_address, addr_q, a;
	logic [COUNT_BITS-1:0] outstanding_command_count;
	logic [BEAT_BITS-1:0] write_beat_payload, read_beat_payload, beat0_q, beat1_q;
	logic [255:0] bb;
	int blocks_q, errors = 0, num_checks = 0, cyc = 0;
	typedef struct {logic [7:0] ad; logic [31:0] ex; logic [1:0] rs;} row_t;
	row_t rows [6] = '{'{8'h00, 32'h0, RESP_OKAY}, '{8'h04, 32'hc, RESP_OKAY}, '{8'h0c, 32'h0, RESP_OKAY},
		'{8'h10, 32'h3e0, RESP_OKAY}, '{8'h14, 32'h0, RESP_OKAY}, '{8'h18, 32'h0, RESP_SLVERR}};

	traffic_test_generator traffic_test_generator_inst (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cmd_request_valid, .target_address, .cmd_accept_ready, .outstanding_command_count,
		.write_beat_valid, .write_beat_payload, .write_accept_ready, .read_beat_valid, .read_beat_payload);
	core_model core_model_inst (.aclk, .aresetn, .stall, .rd_mode, .bad, .cmd_request_valid, .target_address,
		.cmd_accept_ready, .outstanding_command_count, .write_beat_valid, .write_beat_payload, .write_accept_ready,
		.read_beat_valid, .read_beat_payload, .beat0_q, .beat1_q, .addr_q, .blocks_q);

	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] s, input logic [127:0] x);
		num_checks++;
		if (s !== x) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h1;
		@(posedge aclk);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		dt = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rck(input logic [7:0] ad, input logic [31:0] x);
		rd(ad, d, r);
		chk(d, x);
	endtask
	task automatic push(input logic [47:0] ad);
		wr(OFF_ADDR_LO, ad[31:0]);
		wr(OFF_ADDR_HI, {16'h0, ad[47:32]});
	endtask
	task automatic wait_blk(input int n);
		for (int i = 0; i < 2000 && blocks_q < n; i++) @(posedge aclk);
		chk(blocks_q, n);
	endtask
	function automatic logic [31:0] step(input logic [31:0] s);
		step = {s[30:0], s[30] ^ s[20] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_dw(input logic [2:0] p, input int j, input logic [47:0] ad);
		case (p)
			PAT_ZERO: exp_dw = 32'h0;
			PAT_ONE: exp_dw = 32'hffff_ffff;
			default: exp_dw = j == 0 ? ad[31:0] : j == 1 ? {16'h0, ad[47:32]} : p == PAT_DEC ? ~32'(j) : 32'(j);
		endcase
	endfunction
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (rows[i]) begin
			rd(rows[i].ad, d, r);
			chk(d, rows[i].ex);
			chk(r, rows[i].rs);
		end
		for (int p = 0; p < 5; p++) begin
			a = {13'h0, 3'(p), 32'h0000_1000 + 32'(p)};
			push(a);
			if (p == 0) rck(OFF_FREE, 32'h3df);
			wr(OFF_CONTROL, {25'h0, 3'(p), 4'h1});
			if (p == 0) begin
				repeat (20) @(posedge aclk);
				chk(blocks_q, 0);
				chk(addr_q, a);
				stall <= 1'h0;
			end
			wait_blk(p + 1);
			wr(OFF_CONTROL, 32'h0);
			bb = {beat1_q, beat0_q};
			for (int j = 0; j < 8; j++) begin
				e = (p == 2 && j > 2) ? step(bb[32*(j-1)+:32]) : exp_dw(3'(p), j, a);
				if (p != 2 || j != 2) chk(bb[32*j+:32], e);
			end
		end
		rck(OFF_STATUS, 32'hd);
		rck(OFF_DONE, 32'h5);
		wr(OFF_STATUS, 32'h3);
		rck(OFF_STATUS, 32'hc);
		rd_mode <= 1'h1;
		for (int k = 0; k < 2; k++) begin
			bad <= 1'(k);
			push(48'h0000_00c0_0000 + 48'(k));
			wr(OFF_CONTROL, 32'h7);
			wait_blk(6 + k);
			wr(OFF_CONTROL, 32'h0);
			rck(OFF_STATUS, k ? 32'hf : 32'hd);
		end
		rck(OFF_DONE, 32'h7);
		final_report();
	end
endmodule // traffic_test_generator_tb
